// ### design/pcie_ctrl_stat_counters.v
// control and statistic register bank of the pcie host interface
// assumes a plain strobe register port on ref_clk and event pulses from
// the transaction layer on the same clock
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`include "pcie_ctrl_stat_defs.vh"

// Summary of operation
// - control bit 31 set disables the completion time-out mechanism.
// - control bit 30 is set by hardware when self-test finishes successfully.
// - control bit 29 forces low-power link training to count as good.
// - control bit 28 suppresses running disparity error reports.
// - control bit 27 lets L1 entry happen regardless of receive L0s.
// - read-only three-bit L1 idle-time code at bits 23 and 26:25.
// - L1 idle-time code loaded from nonvolatile memory; default all ones.
// - control bit 24 picks L0s entry latency equal or quarter exit.
// - control bit 21 reorders the captured error header log.
// - control bit 20 clear clears pending bit on request deassertion.
// - control bit 9 set always adds reply timer L0s adjustment.
// - control bits 5:0 give no-snoop for six transaction kinds.
// - each counter holds a 3-bit tag and 5-bit function filter.
// - statistic control bits 31, 30, 29 start, stop, reset counters.
// - statistic control bit 28 pairs counters into two 64-bit counters.
// - statistic control bit 27 forwards counter values for testability.
// - statistic control bits 3:0 enable unpaired counters 3:0 individually; when paired, bits 0 and 2 enable the pairs.
// - counters 0 and 2, and 1 and 3 when unpaired, count the event code in their own select byte.
// - two 12-bit credit thresholds at bits 11:0 and 27:16.
// - threshold events count only after passing their threshold.
// - 6-bit retry threshold at 15:10, 10-bit latency threshold at 9:0.
module pcie_ctrl_stat_counters #(
	parameter NUM_EVENTS = 256,
	parameter CNT_WIDTH  = 32
) (
	// clock and reset
	input  wire                  ref_clk,
	input  wire                  nrst,
	// register port
	input  wire [15:0]           regAddr,
	input  wire [31:0]           regWrData,
	input  wire                  regWrite,
	input  wire                  regRead,
	output reg  [31:0]           regRdData,
	// strap and status inputs
	input  wire                  nvmLoadValid,
	input  wire [2:0]            nvmL1Code,
	input  wire                  selfTestDone,
	input  wire                  selfTestPass,
	// transaction layer events
	input  wire [NUM_EVENTS-1:0] eventPulse,
	input  wire [4:0]            eventFunc,
	input  wire [2:0]            eventTag,
	input  wire [11:0]           creditLevel0,
	input  wire [11:0]           creditLevel1,
	input  wire [5:0]            retryLevel,
	input  wire [9:0]            complLatency,
	// control outputs to the link and transaction layer
	output reg                   timeoutDisable,
	output reg                   forceGoodTraining,
	output reg                   disparityErrDisable,
	output reg                   l1EntryIndependent,
	output reg  [2:0]            l1IdleTimeCode,
	output reg                   lowpowerEntryLatencySel,
	output reg                   headerLogReorder,
	output reg                   pendingClearPolicy,
	output reg                   replyTimerAdjustAlways,
	output reg  [5:0]            noSnoop,
	output reg                   countersRunning,
	output reg                   counterTestMode,
	output reg  [31:0]           testForward
);

	reg  [31:0] linkControl;
	reg  [31:0] counter_function_tag_filter;
	reg  [31:0] statControl;
	reg  [31:0] eventSelect;
	reg  [31:0] creditThresh;
	reg  [31:0] retryThresh;
	reg  [CNT_WIDTH-1:0] counter [0:3];
	reg         running;
	reg         selfTestOk;
	reg  [2:0]  l1Code;
	reg  [1:0]  testSel;

	wire wrLink  = regWrite && (regAddr == `OFS_LINK_CONTROL);
	wire wrFunc  = regWrite && (regAddr == `OFS_FUNC_TAG);
	wire wrStat  = regWrite && (regAddr == `OFS_STAT_CONTROL);
	wire wrEvent = regWrite && (regAddr == `OFS_STAT_EVENT);
	wire wrCred  = regWrite && (regAddr == `OFS_STAT_CREDIT);
	wire wrRetry = regWrite && (regAddr == `OFS_STAT_RETRY);
	wire cntReset = wrStat && regWrData[`SC_RESET];
	wire pair64   = statControl[`SC_PAIR64];

	// threshold event hits, one per counting threshold
	wire hitCredit0 = creditLevel0 > creditThresh[11:0];
	wire hitCredit1 = creditLevel1 > creditThresh[27:16];
	wire hitRetry   = retryLevel   > retryThresh[15:10];
	wire hitLatency = complLatency > retryThresh[9:0];

	// counter word index from a byte address
	function [1:0] valueIndex;
		input [15:0] addr;
		begin
			valueIndex = addr[3:2];
		end
	endfunction

	function isValueAddr;
		input [15:0] addr;
		begin
			isValueAddr = (addr[15:4] == `OFS_STAT_VALUE_0 >> 4) &&
			              (addr[3:2] <= 2'h3) && (addr[1:0] == 2'h0);
		end
	endfunction

	// control register; bit 30 and the l1 code are hardware owned
	always @(posedge ref_clk) begin
		if (!nrst) begin
			linkControl <= `LC_RESET;
			selfTestOk  <= 1'b0;
			l1Code      <= `L1_CODE_DEFAULT;
		end else begin
			if (wrLink)
				linkControl <= regWrData & `LC_WR_MASK;
			if (selfTestDone && selfTestPass)
				selfTestOk <= 1'b1;
			if (nvmLoadValid)
				l1Code <= nvmL1Code;
		end
	end

	// filter, selector and threshold registers
	always @(posedge ref_clk) begin
		if (!nrst) begin
			counter_function_tag_filter      <= 32'h00000000;
			eventSelect  <= 32'h00000000;
			creditThresh <= 32'h00000000;
			retryThresh  <= 32'h00000000;
		end else begin
			if (wrFunc)
				counter_function_tag_filter <= regWrData;
			if (wrEvent)
				eventSelect <= regWrData;
			if (wrCred)
				creditThresh <= regWrData & `CREDIT_WR_MASK;
			if (wrRetry)
				retryThresh <= regWrData & `RETRY_WR_MASK;
		end
	end

	// statistic control; start, stop and reset are one-shot commands
	always @(posedge ref_clk) begin
		if (!nrst) begin
			statControl <= 32'h00000000;
			running     <= 1'b0;
		end else if (wrStat) begin
			statControl <= {3'h0, regWrData[28:27], 23'h000000,
			                regWrData[3:0]};
			if (regWrData[`SC_STOP])
				running <= 1'b0;
			else if (regWrData[`SC_START])
				running <= 1'b1;
		end
	end

	// counters; in paired mode 1:0 and 3:2 form 64-bit counters
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : gCnt
			wire [7:0] code = eventSelect[8*i+7:8*i];
			wire [4:0] fnum = counter_function_tag_filter[8*i+4:8*i];
			wire [2:0] tnum = counter_function_tag_filter[8*i+7:8*i+5];
			reg        hit;
			always @* begin
				hit = eventPulse[code];
				if (code == `EV_FUNC_TAG_A || code == `EV_FUNC_TAG_B)
					hit = hit && (eventFunc == fnum) &&
					      (eventTag == tnum);
			end
			wire thrOk = (code[1:0] == 2'h0) ? hitCredit0 :
			             (code[1:0] == 2'h1) ? hitCredit1 :
			             (code[1:0] == 2'h2) ? hitRetry : hitLatency;
			wire isThr = code[7:4] == 4'hF;
			wire inc   = running && statControl[i] &&
			             hit && (!isThr || thrOk);
			if (i % 2 == 0) begin : gLow
				always @(posedge ref_clk) begin
					if (!nrst || cntReset)
						counter[i] <= {CNT_WIDTH{1'b0}};
					else if (inc)
						counter[i] <= counter[i] + 1'b1;
				end
			end else begin : gHigh
				wire lowInc  = gCnt[i-1].inc;
				wire carry   = lowInc && (&counter[i-1]);
				always @(posedge ref_clk) begin
					if (!nrst || cntReset)
						counter[i] <= {CNT_WIDTH{1'b0}};
					else if (pair64 ? carry : inc)
						counter[i] <= counter[i] + 1'b1;
				end
			end
		end
	endgenerate

	// read data, one cycle after the read strobe
	always @(posedge ref_clk) begin
		if (!nrst)
			regRdData <= 32'h00000000;
		else if (regRead) begin
			case (regAddr)
			`OFS_LINK_CONTROL:
				regRdData <= {linkControl[31], selfTestOk, linkControl[29:27],
				              l1Code[1:0], linkControl[24], l1Code[2],
				              linkControl[22:0]};
			`OFS_FUNC_TAG:     regRdData <= counter_function_tag_filter;
			`OFS_STAT_CONTROL: regRdData <= statControl;
			`OFS_STAT_EVENT:   regRdData <= eventSelect;
			`OFS_STAT_CREDIT:  regRdData <= creditThresh;
			`OFS_STAT_RETRY:   regRdData <= retryThresh;
			default: begin
				if (isValueAddr(regAddr))
					regRdData <= counter[valueIndex(regAddr)];
				else
					regRdData <= 32'h00000000;
			end
			endcase
		end else
			regRdData <= 32'h00000000;
	end

	// registered control outputs
	always @(posedge ref_clk) begin
		if (!nrst) begin
			timeoutDisable          <= 1'b0;
			forceGoodTraining       <= 1'b0;
			disparityErrDisable     <= 1'b0;
			l1EntryIndependent      <= 1'b0;
			l1IdleTimeCode          <= `L1_CODE_DEFAULT;
			lowpowerEntryLatencySel <= 1'b0;
			headerLogReorder        <= 1'b0;
			pendingClearPolicy      <= 1'b0;
			replyTimerAdjustAlways  <= 1'b1;
			noSnoop                 <= 6'h00;
			countersRunning         <= 1'b0;
			counterTestMode         <= 1'b0;
			testForward             <= 32'h00000000;
			testSel                 <= 2'h0;
		end else begin
			timeoutDisable          <= linkControl[`LC_TIMEOUT_DIS];
			forceGoodTraining       <= linkControl[`LC_GOOD_TRAINING];
			disparityErrDisable     <= linkControl[`LC_DIS_DISPARITY];
			l1EntryIndependent      <= linkControl[`LC_L1_INDEP];
			l1IdleTimeCode          <= l1Code;
			lowpowerEntryLatencySel <= linkControl[`LC_L0S_LAT_SEL];
			headerLogReorder        <= linkControl[`LC_HDR_ORDER];
			pendingClearPolicy      <= linkControl[`LC_PEND_POLICY];
			replyTimerAdjustAlways  <= linkControl[`LC_REPLY_ADJ];
			noSnoop                 <= linkControl[5:0];
			countersRunning         <= running;
			counterTestMode         <= statControl[`SC_TEST];
			testSel                 <= testSel + 2'h1;
			if (statControl[`SC_TEST])
				testForward <= counter[testSel];
			else
				testForward <= 32'h00000000;
		end
	end

endmodule

// ### design/pcie_ctrl_stat_defs.vh
// register offsets, field positions and reset values of the pcie control
// and statistics bank; included by the bank module only
`ifndef PCIE_CTRL_STAT_DEFS_VH
`define PCIE_CTRL_STAT_DEFS_VH

`define OFS_LINK_CONTROL   16'h5B00
`define OFS_FUNC_TAG       16'h5B08
`define OFS_STAT_CONTROL   16'h5B10
`define OFS_STAT_EVENT     16'h5B14
`define OFS_STAT_CREDIT    16'h5B18
`define OFS_STAT_RETRY     16'h5B1C
`define OFS_STAT_VALUE_0   16'h5B20
`define OFS_STAT_VALUE_1   16'h5B24
`define OFS_STAT_VALUE_2   16'h5B28
`define OFS_STAT_VALUE_3   16'h5B2C

// link control fields
`define LC_TIMEOUT_DIS     31
`define LC_SELFTEST_OK     30
`define LC_GOOD_TRAINING   29
`define LC_DIS_DISPARITY   28
`define LC_L1_INDEP        27
`define LC_L1_LSB_HI       26
`define LC_L1_LSB_LO       25
`define LC_L0S_LAT_SEL     24
`define LC_L1_MSB          23
`define LC_INIT_BIT        22
`define LC_HDR_ORDER       21
`define LC_PEND_POLICY     20
`define LC_REPLY_ADJ       9
`define LC_RESET           32'h00000200
`define LC_WR_MASK         32'hB970023F
`define L1_CODE_DEFAULT    3'h7

// statistic control fields
`define SC_START           31
`define SC_STOP            30
`define SC_RESET           29
`define SC_PAIR64          28
`define SC_TEST            27
`define SC_WR_MASK         32'hF800000F

// threshold masks
`define CREDIT_WR_MASK     32'h0FFF0FFF
`define RETRY_WR_MASK      32'h0000FFFF

// event codes qualified by function and tag
`define EV_FUNC_TAG_A      8'h06
`define EV_FUNC_TAG_B      8'h1D

`endif

// ### tb/pcie_ctrl_stat_monitor.sv
// port checker of the pcie control and statistics bank
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/10ps
module pcie_ctrl_stat_monitor #(
	parameter NUM_EVENTS = 256,
	parameter CNT_WIDTH  = 32
) (
	// register port
	input logic        ref_clk,
	input logic        nrst,
	input logic [15:0] regAddr,
	input logic [31:0] regWrData,
	input logic        regWrite,
	input logic        regRead,
	input logic [31:0] regRdData,
	// load and control outputs
	input logic        nvmLoadValid,
	input logic [2:0]  nvmL1Code,
	input logic        timeoutDisable,
	input logic [2:0]  l1IdleTimeCode,
	input logic        replyTimerAdjustAlways,
	input logic [5:0]  noSnoop,
	input logic        countersRunning,
	input logic        counterTestMode
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire lcWr = regWrite && regAddr == 16'h5B00;
	wire scWr = regWrite && regAddr == 16'h5B10;
	property p_rd; !regRead |=> regRdData == 32'h0; endproperty
	a_rd: assert property (p_rd) else $error("stray read data");
	property p_tmo; lcWr |-> ##2 timeoutDisable == $past(regWrData[31], 2);
	endproperty
	a_tmo: assert property (p_tmo) else $error("timeout bit");
	property p_ns; lcWr |-> ##2 noSnoop == $past(regWrData[5:0], 2); endproperty
	a_ns: assert property (p_ns) else $error("no-snoop bits");
	property p_adj; lcWr |-> ##2 replyTimerAdjustAlways == $past(regWrData[9], 2);
	endproperty
	a_adj: assert property (p_adj) else $error("reply adjust");
	property p_ld; nvmLoadValid |-> ##2 l1IdleTimeCode == $past(nvmL1Code, 2);
	endproperty
	a_ld: assert property (p_ld) else $error("idle code load");
	property p_hold; $changed(l1IdleTimeCode) |-> $past(nvmLoadValid, 2);
	endproperty
	a_hold: assert property (p_hold) else $error("idle code moved");
	property p_go; scWr && regWrData[31] && !regWrData[30] |-> ##2 countersRunning;
	endproperty
	a_go: assert property (p_go) else $error("start ignored");
	property p_halt; scWr && regWrData[30] |-> ##2 !countersRunning;
	endproperty
	a_halt: assert property (p_halt) else $error("stop ignored");
	property p_tst; scWr |-> ##2 counterTestMode == $past(regWrData[27], 2);
	endproperty
	a_tst: assert property (p_tst) else $error("test mode bit");
	property p_rst; $rose(nrst) |-> replyTimerAdjustAlways && l1IdleTimeCode == 3'h7;
	endproperty
	a_rst: assert property (p_rst) else $error("reset values");
	cover property (lcWr);
	cover property (nvmLoadValid);
	cover property (scWr && regWrData[31]);
endmodule

bind pcie_ctrl_stat_counters pcie_ctrl_stat_monitor #(
	.NUM_EVENTS(NUM_EVENTS),
	.CNT_WIDTH(CNT_WIDTH)
) i_pcie_ctrl_stat_monitor (.*);

// ### tb/tl_event_source.sv
// event source standing for the transaction layer
// assumes bench requests change just after rising ref_clk
`timescale 1ns/10ps
module tl_event_source #(
	parameter NUM_EVENTS = 256
) (
	// clock and request
	input  logic                  ref_clk,
	input  logic                  fire,
	input  logic [7:0]            code,
	input  logic [4:0]            func,
	input  logic [2:0]            tag,
	// event lines
	output logic [NUM_EVENTS-1:0] eventPulse = '0,
	output logic [4:0]            eventFunc = 5'h0,
	output logic [2:0]            eventTag = 3'h0
);
	// qualifiers mean nothing without a pulse, so scramble them
	always @(posedge ref_clk) begin
		eventPulse <= fire ? {{(NUM_EVENTS-1){1'b0}}, 1'b1} << code : '0;
		eventFunc  <= fire ? func : ~eventFunc;
		eventTag   <= fire ? tag : ~eventTag;
	end
endmodule

// ### tb/pcie_ctrl_stat_counters_tb.sv
// self-checking bench of the pcie control and statistics bank
// assumes the bank, its checker and the event source are compiled first
`timescale 1ns/10ps
module pcie_ctrl_stat_counters_tb;
	logic         ref_clk = 0, nrst = 0, regWrite = 0, regRead = 0;
	logic [15:0]  regAddr = 16'h0;
	logic [31:0]  regWrData = 32'h0, regRdData, testForward, r;
	logic         nvmLoadValid = 0, selfTestDone = 0, selfTestPass = 0;
	logic [2:0]   nvmL1Code = 3'h0, tag = 3'h0, eventTag, l1IdleTimeCode;
	logic         fire = 0, rdSeen = 0;
	logic [7:0]   code = 8'h0;
	logic [4:0]   func = 5'h0, eventFunc;
	logic [11:0]  creditLevel0 = 12'h0, creditLevel1 = 12'h0;
	logic [5:0]   retryLevel = 6'h0, noSnoop;
	logic [9:0]   complLatency = 10'h0;
	logic [255:0] eventPulse;
	logic         timeoutDisable, forceGoodTraining, disparityErrDisable;
	logic         l1EntryIndependent, lowpowerEntryLatencySel;
	logic         headerLogReorder, pendingClearPolicy, replyTimerAdjustAlways;
	logic         countersRunning, counterTestMode;
	logic [31:0]  q[$];
	logic [15:0]  ra[4] = '{16'h5B08, 16'h5B14, 16'h5B18, 16'h5B1C};
	logic [31:0]  rm[4] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h0FFF0FFF, 32'h0000FFFF};
	int           err_count = 0, comparisons = 0;

	pcie_ctrl_stat_counters i_pcie_ctrl_stat_counters (.*);
	tl_event_source i_tl_event_source (.*);

	initial forever #2 ref_clk = ~ref_clk;

	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		comparisons++;
		if (act !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, act, exp);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
		regWrite <= w;
		regRead <= !w;
		regAddr <= a;
		regWrData <= d;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e);
		q.push_back(e);
		acc(0, a, 32'h0);
	endtask
	task automatic idle(input int n);
		regWrite <= 0;
		regRead <= 0;
		fire <= 0;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic ev(input logic [7:0] c, input int n, input logic [4:0] f,
		input logic [2:0] t);
		regWrite <= 0;
		regRead <= 0;
		fire <= 1;
		code <= c;
		func <= f;
		tag <= t;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic end_sim;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rdSeen)
			chk(regRdData, q.pop_front());
		rdSeen <= regRead;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		end_sim;
	end

	initial begin
		r = $urandom(8116);
		repeat (16) @(posedge ref_clk);
		nrst <= 1;
		@(posedge ref_clk);
		rd(16'h5B00, 32'h06800200);
		rd(16'h5B04, 32'h0);
		for (int i = 0; i < 6; i++) begin
			r = $urandom;
			acc(1, 16'h5B00, r);
			rd(16'h5B00, r & 32'hB970023F | 32'h06800000);
			idle(2);
			chk({timeoutDisable, forceGoodTraining, disparityErrDisable,
				l1EntryIndependent, lowpowerEntryLatencySel, headerLogReorder,
				pendingClearPolicy, replyTimerAdjustAlways, noSnoop},
				{r[31], r[29:27], r[24], r[21:20], r[9], r[5:0]});
		end
		acc(1, 16'h5B00, 32'h00400000);
		selfTestDone <= 1;
		idle(2);
		rd(16'h5B00, 32'h06C00000);
		selfTestPass <= 1;
		nvmL1Code <= 3'h2;
		idle(2);
		nvmLoadValid <= 1;
		@(posedge ref_clk);
		nvmLoadValid <= 0;
		idle(2);
		rd(16'h5B00, 32'h44400000);
		chk(l1IdleTimeCode, 3'h2);
		for (int i = 0; i < 4; i++) begin
			r = $urandom;
			acc(1, ra[i], r);
			rd(ra[i], r & rm[i]);
		end
		acc(1, 16'h5B10, 32'hE8000003);
		rd(16'h5B10, 32'h08000003);
		acc(1, 16'h5B14, 32'h43420640);
		acc(1, 16'h5B08, 32'h00006500);
		acc(1, 16'h5B10, 32'h20000007);
		acc(1, 16'h5B10, 32'h80000007);
		ev(8'h40, 5, 5'h05, 3'h3);
		ev(8'h42, 3, 5'h05, 3'h3);
		ev(8'h06, 2, 5'h05, 3'h3);
		ev(8'h06, 1, 5'h04, 3'h3);
		ev(8'h43, 4, 5'h05, 3'h3);
		idle(3);
		rd(16'h5B20, 32'h5);
		rd(16'h5B24, 32'h2);
		rd(16'h5B28, 32'h3);
		rd(16'h5B2C, 32'h0);
		acc(1, 16'h5B10, 32'h40000007);
		ev(8'h40, 2, 5'h05, 3'h3);
		idle(3);
		rd(16'h5B20, 32'h5);
		acc(1, 16'h5B10, 32'h20000007);
		idle(2);
		rd(16'h5B20, 32'h0);
		creditLevel0 <= 12'h100;
		acc(1, 16'h5B18, 32'h00000100);
		acc(1, 16'h5B14, 32'h000000F0);
		acc(1, 16'h5B10, 32'h80000001);
		ev(8'hF0, 4, 5'h00, 3'h0);
		idle(8);
		rd(16'h5B20, 32'h0);
		creditLevel0 <= 12'h101;
		ev(8'hF0, 4, 5'h00, 3'h0);
		idle(3);
		rd(16'h5B20, 32'h4);
		idle(3);
		end_sim;
	end
endmodule
